// ==== shared/dbs_sel_pkg.sv ====
// Constants shared by the duplex bus port selector: codes, field positions and timing.
// Assumes a single 20 MHz system clock; every time below is turned into cycles of it.
//
// Contract
// - Fault flag sense inverted for command strobes.
// - Processor clock passes through to the peripheral.
// - Clock check results appear in status word.
// - Bipolar responses pulse 200 ns per transition.
// - Word and attention drivers pulse on rises only.
// - Word pulses fire on echo rise, gated by data.
// - Normal mode words come from the peripheral.
// - Maintenance words come from loop register or status.
// - Maintenance poll answers with all ones.
// - Two sides, at most one connected at once.
// - Port enable flop gates each side's bus traffic.
// - Route flop steers controls to peripheral or blocks.
// - Two flops give out, maintenance, normal states.
// - Normal side connects its bus to the peripheral.
// - Commands never make a side normal while the other side is normal.
// - Maintenance blocks peripheral, selector answers itself.
// - Third flop gives commanded maintenance transfer request.
// - Command with word bit 0 decodes seven codes.
// - Takeover with shared address switches sides, else clears.
// - Power transitions hold all control flops reset.
// - Commanded transfer request holds until write, read or takeover strobe.
package dbs_sel_pkg;

	localparam int          ADDR_W    = 6;
	localparam int          WORD_W    = 18;
	localparam int          CODE_W    = 5;
	localparam int          CNT_W     = 6;
	localparam logic [5:0]  MAINT_ADDR = 6'h3c;
	localparam int          MAINT_BIT = 0;

	localparam logic [4:0]  CMD_NONE      = 5'h01;
	localparam logic [4:0]  CMD_ROUTE_CLR = 5'h07;
	localparam logic [4:0]  CMD_ROUTE_SET = 5'h0b;
	localparam logic [4:0]  CMD_PORT_OFF  = 5'h0d;
	localparam logic [4:0]  CMD_PORT_ON   = 5'h13;
	localparam logic [4:0]  CMD_XFER_SET  = 5'h15;
	localparam logic [4:0]  CMD_ATTN      = 5'h19;

	localparam int STB_CMD = 0;
	localparam int STB_WR  = 1;
	localparam int STB_RD  = 2;
	localparam int STB_ST  = 3;
	localparam int STB_POLL = 4;
	localparam int STB_TAKE = 5;
	localparam int STB_N   = 6;

	localparam int RSP_ECHO = 0;
	localparam int RSP_IDLE = 1;
	localparam int RSP_FAULT = 2;
	localparam int RSP_REQ  = 3;
	localparam int RSP_N    = 4;
	localparam int DEV_ATTN = 4;
	localparam int DEVIN_N  = 5;

	localparam int PL_BIT = 16;
	localparam int PH_BIT = 17;
	localparam int ST_MY_CLK   = 6;
	localparam int ST_OT_CLK   = 7;
	localparam int ST_MY_ROUTE = 8;
	localparam int ST_OT_ROUTE = 9;
	localparam int ST_MY_ON    = 10;
	localparam int ST_OT_ON    = 11;
	localparam int ST_DEV_REQ  = 12;
	localparam int ST_DEV_ATTN = 13;
	localparam int ST_MY_XFER  = 14;
	localparam int ST_OT_XFER  = 15;

	localparam int CLK_PERIOD_NS     = 50;
	localparam int PULSE_NS          = 200;
	localparam int CLOCK_TIMEOUT_NS  = 2000;
	localparam int PULSE_CYCLES_RAW  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYCLES      = (PULSE_CYCLES_RAW < 1) ? 1 : PULSE_CYCLES_RAW;
	localparam int TIMEOUT_CYCLES    = CLOCK_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] PULSE_LOAD   = CNT_W'(PULSE_CYCLES - 1);
	localparam logic [CNT_W-1:0] TIMEOUT_CNT  = CNT_W'(TIMEOUT_CYCLES);

	typedef enum logic [1:0] {MODE_OUT, MODE_MAINT, MODE_NORMAL} mode_t;

endpackage : dbs_sel_pkg

// ==== core/duplex_bus_port_selector.sv ====
// Duplex bus port selector: joins one peripheral to either of two processor bus sides.
// Assumes the bus receivers deliver levels; all pins but RESET_N_I are sampled through two flip-flops.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module duplex_bus_port_selector
(
	input  wire logic                  CLK_I,
	input  wire logic                  RESET_N_I,
	input  wire logic                  POWER_GOOD_I,
	input  wire logic [4:0]            STRAP_ADDR_I,
	input  wire logic [5:0]            STRAP_CODE_I,
	input  wire logic [1:0][5:0]       BUS_ADDR_I,
	input  wire logic [1:0]            BUS_COMMAND_I,
	input  wire logic [1:0]            BUS_WRITE_I,
	input  wire logic [1:0]            BUS_READ_I,
	input  wire logic [1:0]            BUS_STATUS_I,
	input  wire logic [1:0]            BUS_POLL_I,
	input  wire logic [1:0]            BUS_TAKEOVER_I,
	input  wire logic [1:0][17:0]      BUS_WORD_I,
	input  wire logic [1:0]            BUS_CLOCK_I,
	output logic      [1:0][3:0]       RESP_PULSE_O,
	output logic      [1:0][3:0]       RESP_LEVEL_O,
	output logic      [1:0]            ATTN_PULSE_O,
	output logic      [1:0][17:0]      WORD_PULSE_O,
	output logic      [1:0][1:0]       SIDE_MODE_O,
	input  wire logic                  DEV_ECHO_I,
	input  wire logic                  DEV_IDLE_I,
	input  wire logic                  DEV_FAULT_I,
	input  wire logic                  DEV_ATTN_I,
	input  wire logic                  DEV_REQUEST_I,
	input  wire logic [17:0]           DEV_WORD_I,
	output logic      [5:0]            DEV_ADDR_O,
	output logic                       DEV_COMMAND_O,
	output logic                       DEV_WRITE_O,
	output logic                       DEV_READ_O,
	output logic                       DEV_STATUS_O,
	output logic                       DEV_POLL_O,
	output logic                       DEV_CLOCK_O,
	output logic      [17:0]           DEV_WORD_O,
	output logic                       DEV_WORD_OE_O
);

	logic                                        pwr_s1, pwr_s2, rst;
	logic [4:0]                                  strap_addr_s1, strap_addr_s2;
	logic [5:0]                                  strap_code_s1, strap_code_s2;
	logic [dbs_sel_pkg::DEVIN_N-1:0]             dev_s1, dev_s2;
	logic [17:0]                                 dev_word_s1, dev_word_s2;
	logic [1:0][dbs_sel_pkg::STB_N-1:0]          stb_s1, stb_s2, stb_d, rise;
	logic [1:0][5:0]                             addr_s1, addr_s2;
	logic [1:0][17:0]                            word_s1, word_s2;
	logic [1:0]                                  clk_s1, clk_s2, clk_d;
	logic [1:0][dbs_sel_pkg::CNT_W-1:0]          ck_cnt_reg;
	logic [1:0]                                  clock_ok_reg;
	logic [1:0]                                  route_reg, on_reg, xfer_reg;
	logic [1:0]                                  normal, maint, conn;
	logic [1:0]                                  my_hit, maint_hit, cmd_ok, cmd_valid, take_maint;
	logic [1:0][17:0]                            loop_reg, self_word_reg;
	logic [1:0]                                  self_echo_reg, self_fault_reg, self_attn_reg;
	logic [1:0][3:0]                             rsp_lvl, rsp_prev_reg;
	logic [1:0]                                  attn_lvl, attn_prev_reg;
	logic [1:0][17:0]                            word_src;
	logic [1:0][3:0][dbs_sel_pkg::CNT_W-1:0]     rsp_cnt_reg;
	logic [1:0][dbs_sel_pkg::CNT_W-1:0]          attn_cnt_reg;

	// Power loss holds every control flop reset, as the bus power sequencing does.
	assign rst = ~RESET_N_I | ~pwr_s2;

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			pwr_s1        <= 1'b0;
			pwr_s2        <= 1'b0;
			strap_addr_s1 <= '0;
			strap_addr_s2 <= '0;
			strap_code_s1 <= '0;
			strap_code_s2 <= '0;
			dev_s1        <= '0;
			dev_s2        <= '0;
			dev_word_s1   <= '0;
			dev_word_s2   <= '0;
		end
		else
		begin
			pwr_s1        <= POWER_GOOD_I;
			pwr_s2        <= pwr_s1;
			strap_addr_s1 <= STRAP_ADDR_I;
			strap_addr_s2 <= strap_addr_s1;
			strap_code_s1 <= STRAP_CODE_I;
			strap_code_s2 <= strap_code_s1;
			dev_s1        <= {DEV_ATTN_I, DEV_REQUEST_I, DEV_FAULT_I, DEV_IDLE_I, DEV_ECHO_I};
			dev_s2        <= dev_s1;
			dev_word_s1   <= DEV_WORD_I;
			dev_word_s2   <= dev_word_s1;
		end
	end

	assign normal = route_reg & on_reg;
	assign maint  = ~route_reg & on_reg;
	assign conn   = {normal[1] & ~normal[0], normal[0]};

	function automatic logic is_valid(input logic [4:0] code);
		case (code)
			dbs_sel_pkg::CMD_NONE,
			dbs_sel_pkg::CMD_ROUTE_CLR,
			dbs_sel_pkg::CMD_ROUTE_SET,
			dbs_sel_pkg::CMD_PORT_OFF,
			dbs_sel_pkg::CMD_PORT_ON,
			dbs_sel_pkg::CMD_XFER_SET,
			dbs_sel_pkg::CMD_ATTN: return 1'b1;
			default:               return 1'b0;
		endcase
	endfunction : is_valid

	// Status bits go out inverted, strap code bits true; both bytes carry odd parity.
	function automatic logic [17:0] status_word(input logic [9:0] flags, input logic [5:0] code);
		logic [15:0] d;
		d = {~flags, code};
		return {~^d[15:8], ~^d[7:0], d};
	endfunction : status_word

	for (genvar s = 0; s < 2; s++)
	begin : g_side
		always_ff @(posedge CLK_I)
		begin
			if (!RESET_N_I)
			begin
				stb_s1[s]  <= '0;
				stb_s2[s]  <= '0;
				stb_d[s]   <= '0;
				addr_s1[s] <= '0;
				addr_s2[s] <= '0;
				word_s1[s] <= '0;
				word_s2[s] <= '0;
				clk_s1[s]  <= 1'b0;
				clk_s2[s]  <= 1'b0;
				clk_d[s]   <= 1'b0;
			end
			else
			begin
				stb_s1[s]  <= {BUS_TAKEOVER_I[s], BUS_POLL_I[s], BUS_STATUS_I[s],
					BUS_READ_I[s], BUS_WRITE_I[s], BUS_COMMAND_I[s]};
				stb_s2[s]  <= stb_s1[s];
				stb_d[s]   <= stb_s2[s];
				addr_s1[s] <= BUS_ADDR_I[s];
				addr_s2[s] <= addr_s1[s];
				word_s1[s] <= BUS_WORD_I[s];
				word_s2[s] <= word_s1[s];
				clk_s1[s]  <= BUS_CLOCK_I[s];
				clk_s2[s]  <= clk_s1[s];
				clk_d[s]   <= clk_s2[s];
			end
		end

		assign rise[s]       = stb_s2[s] & ~stb_d[s];
		assign my_hit[s]     = (addr_s2[s][4:0] == strap_addr_s2) && (^addr_s2[s]);
		assign maint_hit[s]  = addr_s2[s] == dbs_sel_pkg::MAINT_ADDR;
		assign cmd_ok[s]     = rise[s][dbs_sel_pkg::STB_CMD]
			& word_s2[s][dbs_sel_pkg::MAINT_BIT] & my_hit[s];
		assign cmd_valid[s]  = is_valid(word_s2[s][dbs_sel_pkg::CODE_W-1:0]);
		assign take_maint[s] = rise[s][dbs_sel_pkg::STB_TAKE] & maint_hit[s];

		always_ff @(posedge CLK_I)
		begin
			if (rst)
			begin
				ck_cnt_reg[s]   <= '0;
				clock_ok_reg[s] <= 1'b0;
			end
			else if (clk_s2[s] != clk_d[s])
			begin
				ck_cnt_reg[s]   <= '0;
				clock_ok_reg[s] <= 1'b1;
			end
			else if (ck_cnt_reg[s] == dbs_sel_pkg::TIMEOUT_CNT)
				clock_ok_reg[s] <= 1'b0;
			else
				ck_cnt_reg[s]   <= ck_cnt_reg[s] + 1'b1;
		end

		always_ff @(posedge CLK_I)
		begin
			if (rst)
				xfer_reg[s] <= 1'b0;
			else if (cmd_ok[s] && word_s2[s][4:0] == dbs_sel_pkg::CMD_XFER_SET)
				xfer_reg[s] <= 1'b1;
			else if (rise[s][dbs_sel_pkg::STB_WR] || rise[s][dbs_sel_pkg::STB_RD]
				|| rise[s][dbs_sel_pkg::STB_TAKE])
				xfer_reg[s] <= 1'b0;
		end

		always_ff @(posedge CLK_I)
		begin
			if (rst)
			begin
				loop_reg[s]       <= '0;
				self_word_reg[s]  <= '0;
				self_echo_reg[s]  <= 1'b0;
				self_fault_reg[s] <= 1'b0;
				self_attn_reg[s]  <= 1'b0;
			end
			else if (maint[s] && (my_hit[s] || maint_hit[s]) && rise[s][dbs_sel_pkg::STB_WR])
			begin
				loop_reg[s]      <= word_s2[s];
				self_word_reg[s] <= '0;
				self_echo_reg[s] <= 1'b1;
			end
			else if (maint[s] && (my_hit[s] || maint_hit[s]) && rise[s][dbs_sel_pkg::STB_RD])
			begin
				self_word_reg[s] <= loop_reg[s];
				self_echo_reg[s] <= 1'b1;
			end
			else if (maint[s] && (my_hit[s] || maint_hit[s]) && rise[s][dbs_sel_pkg::STB_ST])
			begin
				self_word_reg[s] <= status_word({xfer_reg[1-s], xfer_reg[s], dev_s2[dbs_sel_pkg::DEV_ATTN],
					dev_s2[dbs_sel_pkg::RSP_REQ], on_reg[1-s], on_reg[s], route_reg[1-s],
					route_reg[s], clock_ok_reg[1-s], clock_ok_reg[s]}, strap_code_s2);
				self_echo_reg[s] <= 1'b1;
			end
			else if (maint[s] && maint_hit[s] && rise[s][dbs_sel_pkg::STB_POLL])
			begin
				self_word_reg[s] <= '1;
				self_echo_reg[s] <= 1'b1;
			end
			else if (cmd_ok[s] && on_reg[s])
			begin
				self_word_reg[s]  <= '0;
				self_echo_reg[s]  <= 1'b1;
				self_fault_reg[s] <= cmd_valid[s];
				self_attn_reg[s]  <= word_s2[s][4:0] == dbs_sel_pkg::CMD_ATTN;
			end
			else if (stb_s2[s] == '0)
			begin
				self_echo_reg[s]  <= 1'b0;
				self_fault_reg[s] <= 1'b0;
				self_attn_reg[s]  <= 1'b0;
			end
		end

		always_comb
		begin
			rsp_lvl[s]  = '0;
			attn_lvl[s] = 1'b0;
			word_src[s] = '0;
			if (conn[s])
			begin
				rsp_lvl[s][dbs_sel_pkg::RSP_ECHO]  = dev_s2[dbs_sel_pkg::RSP_ECHO];
				rsp_lvl[s][dbs_sel_pkg::RSP_IDLE]  = dev_s2[dbs_sel_pkg::RSP_IDLE];
				rsp_lvl[s][dbs_sel_pkg::RSP_FAULT] = dev_s2[dbs_sel_pkg::RSP_FAULT]
					| self_fault_reg[s];
				rsp_lvl[s][dbs_sel_pkg::RSP_REQ]   = dev_s2[dbs_sel_pkg::RSP_REQ] | xfer_reg[s];
				attn_lvl[s] = dev_s2[dbs_sel_pkg::DEV_ATTN] | self_attn_reg[s];
				word_src[s] = dev_word_s2;
			end
			else if (on_reg[s])
			begin
				rsp_lvl[s][dbs_sel_pkg::RSP_ECHO]  = self_echo_reg[s];
				rsp_lvl[s][dbs_sel_pkg::RSP_IDLE]  = self_echo_reg[s];
				rsp_lvl[s][dbs_sel_pkg::RSP_FAULT] = self_fault_reg[s];
				rsp_lvl[s][dbs_sel_pkg::RSP_REQ]   = xfer_reg[s];
				attn_lvl[s] = self_attn_reg[s];
				word_src[s] = self_word_reg[s];
			end
		end

		for (genvar i = 0; i < dbs_sel_pkg::RSP_N; i++)
		begin : g_rsp
			always_ff @(posedge CLK_I)
			begin
				if (rst)
				begin
					rsp_prev_reg[s][i] <= 1'b0;
					rsp_cnt_reg[s][i]  <= '0;
					RESP_PULSE_O[s][i] <= 1'b0;
					RESP_LEVEL_O[s][i] <= 1'b0;
				end
				else if (rsp_lvl[s][i] != rsp_prev_reg[s][i])
				begin
					rsp_prev_reg[s][i] <= rsp_lvl[s][i];
					rsp_cnt_reg[s][i]  <= dbs_sel_pkg::PULSE_LOAD;
					RESP_PULSE_O[s][i] <= 1'b1;
					RESP_LEVEL_O[s][i] <= rsp_lvl[s][i];
				end
				else if (rsp_cnt_reg[s][i] != '0)
					rsp_cnt_reg[s][i]  <= rsp_cnt_reg[s][i] - 1'b1;
				else
					RESP_PULSE_O[s][i] <= 1'b0;
			end
		end

		always_ff @(posedge CLK_I)
		begin
			if (rst)
				WORD_PULSE_O[s] <= '0;
			else if (rsp_lvl[s][dbs_sel_pkg::RSP_ECHO] && !rsp_prev_reg[s][dbs_sel_pkg::RSP_ECHO])
				WORD_PULSE_O[s] <= word_src[s];
			else if (rsp_cnt_reg[s][dbs_sel_pkg::RSP_ECHO] == '0)
				WORD_PULSE_O[s] <= '0;
		end

		always_ff @(posedge CLK_I)
		begin
			if (rst)
			begin
				attn_prev_reg[s] <= 1'b0;
				attn_cnt_reg[s]  <= '0;
				ATTN_PULSE_O[s]  <= 1'b0;
			end
			else
			begin
				attn_prev_reg[s] <= attn_lvl[s];
				if (attn_lvl[s] && !attn_prev_reg[s])
				begin
					attn_cnt_reg[s] <= dbs_sel_pkg::PULSE_LOAD;
					ATTN_PULSE_O[s] <= 1'b1;
				end
				else if (attn_cnt_reg[s] != '0)
					attn_cnt_reg[s] <= attn_cnt_reg[s] - 1'b1;
				else
					ATTN_PULSE_O[s] <= 1'b0;
			end
		end

		always_ff @(posedge CLK_I)
		begin
			if (rst)
				SIDE_MODE_O[s] <= dbs_sel_pkg::MODE_OUT;
			else if (normal[s])
				SIDE_MODE_O[s] <= dbs_sel_pkg::MODE_NORMAL;
			else if (maint[s])
				SIDE_MODE_O[s] <= dbs_sel_pkg::MODE_MAINT;
			else
				SIDE_MODE_O[s] <= dbs_sel_pkg::MODE_OUT;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (rst)
		begin
			route_reg <= '0;
			on_reg    <= '0;
		end
		else if (take_maint[0])
		begin
			route_reg <= 2'h1;
			on_reg    <= 2'h1;
		end
		else if (take_maint[1])
		begin
			route_reg <= 2'h2;
			on_reg    <= 2'h2;
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (cmd_ok[s])
				begin
					case (word_s2[s][dbs_sel_pkg::CODE_W-1:0])
						dbs_sel_pkg::CMD_ROUTE_CLR: route_reg[s] <= 1'b0;
						dbs_sel_pkg::CMD_ROUTE_SET: if (!(on_reg[s] && normal[1-s]))
							route_reg[s] <= 1'b1;
						dbs_sel_pkg::CMD_PORT_OFF:  on_reg[s] <= 1'b0;
						dbs_sel_pkg::CMD_PORT_ON:   if (!(route_reg[s] && normal[1-s]))
							on_reg[s] <= 1'b1;
						default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (rst || conn == '0)
		begin
			DEV_ADDR_O    <= '0;
			DEV_COMMAND_O <= 1'b0;
			DEV_WRITE_O   <= 1'b0;
			DEV_READ_O    <= 1'b0;
			DEV_STATUS_O  <= 1'b0;
			DEV_POLL_O    <= 1'b0;
			DEV_CLOCK_O   <= 1'b0;
			DEV_WORD_O    <= '0;
			DEV_WORD_OE_O <= 1'b0;
		end
		else
		begin
			// Only the connected side drives; a maintenance side is never selected here.
			DEV_ADDR_O    <= addr_s2[conn[1]];
			DEV_COMMAND_O <= stb_s2[conn[1]][dbs_sel_pkg::STB_CMD]
				& ~word_s2[conn[1]][dbs_sel_pkg::MAINT_BIT];
			DEV_WRITE_O   <= stb_s2[conn[1]][dbs_sel_pkg::STB_WR];
			DEV_READ_O    <= stb_s2[conn[1]][dbs_sel_pkg::STB_RD];
			DEV_STATUS_O  <= stb_s2[conn[1]][dbs_sel_pkg::STB_ST];
			DEV_POLL_O    <= stb_s2[conn[1]][dbs_sel_pkg::STB_POLL] & ~maint_hit[conn[1]];
			DEV_CLOCK_O   <= clk_s2[conn[1]];
			DEV_WORD_O    <= word_s2[conn[1]];
			// Receivers let go of the word lines while the peripheral is asked to drive them.
			DEV_WORD_OE_O <= ~(stb_s2[conn[1]][dbs_sel_pkg::STB_RD]
				| stb_s2[conn[1]][dbs_sel_pkg::STB_ST] | stb_s2[conn[1]][dbs_sel_pkg::STB_POLL]);
		end
	end

endmodule : duplex_bus_port_selector

`default_nettype wire

// ==== verif/dbs_sel_checker.sv ====
// Concurrent checks on the duplex bus port selector's top-level ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dbs_sel_checker
(
	input wire logic             CLK_I,
	input wire logic             RESET_N_I,
	input wire logic [1:0][5:0]  BUS_ADDR_I,
	input wire logic [1:0]       BUS_WRITE_I,
	input wire logic [1:0]       BUS_READ_I,
	input wire logic [1:0]       BUS_POLL_I,
	input wire logic [1:0]       BUS_TAKEOVER_I,
	input wire logic [1:0]       BUS_CLOCK_I,
	input wire logic [1:0][3:0]  RESP_PULSE_O,
	input wire logic [1:0][3:0]  RESP_LEVEL_O,
	input wire logic [1:0]       ATTN_PULSE_O,
	input wire logic [1:0][17:0] WORD_PULSE_O,
	input wire logic [1:0][1:0]  SIDE_MODE_O,
	input wire logic             DEV_COMMAND_O,
	input wire logic             DEV_WRITE_O,
	input wire logic             DEV_READ_O,
	input wire logic             DEV_CLOCK_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	logic [3:0] clr_cnt_reg;
	logic       no_norm;
	assign no_norm = SIDE_MODE_O[0] != 2'h2 && SIDE_MODE_O[1] != 2'h2;
	// Clearing strobes land a few cycles late, so their memory lingers.
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			clr_cnt_reg <= 4'h0;
		else if (BUS_WRITE_I[1] || BUS_READ_I[1] || BUS_TAKEOVER_I[1])
			clr_cnt_reg <= 4'hf;
		else if (clr_cnt_reg != 4'h0)
			clr_cnt_reg <= clr_cnt_reg - 4'h1;
	end
	sequence pulse4_s(sig);
		sig [*4] ##1 !sig;
	endsequence
	one_normal_a: assert property (!(SIDE_MODE_O[0] == 2'h2 && SIDE_MODE_O[1] == 2'h2))
		else $error("both sides normal");
	reset_out_a: assert property ($rose(RESET_N_I) |-> SIDE_MODE_O == '0 && RESP_PULSE_O == '0)
		else $error("outputs not clear after reset");
	dev_quiet_a: assert property (no_norm [*4] |-> !DEV_WRITE_O && !DEV_READ_O && !DEV_COMMAND_O)
		else $error("device strobe without normal side");
	echo_width_a: assert property ($rose(RESP_PULSE_O[1][0]) |-> pulse4_s(RESP_PULSE_O[1][0]))
		else $error("echo pulse width wrong");
	attn_width_a: assert property ($rose(ATTN_PULSE_O[1]) |-> pulse4_s(ATTN_PULSE_O[1]))
		else $error("attention pulse width wrong");
	word_gated_a: assert property (WORD_PULSE_O[1] != '0 |-> RESP_PULSE_O[1][0] && RESP_LEVEL_O[1][0])
		else $error("word pulse without echo rise");
	clock_pass_a: assert property ((SIDE_MODE_O[0] == 2'h2) [*6] ##0 $rose(BUS_CLOCK_I[0])
		|-> ##[1:5] $rose(DEV_CLOCK_O))
		else $error("clock not forwarded");
	poll_ones_a: assert property (SIDE_MODE_O[1] == 2'h1 && $rose(BUS_POLL_I[1])
		&& BUS_ADDR_I[1] == dbs_sel_pkg::MAINT_ADDR |-> ##[2:6] WORD_PULSE_O[1] == '1)
		else $error("poll answer not all ones");
	xfer_hold_a: assert property ($fell(RESP_LEVEL_O[1][3]) && $past(SIDE_MODE_O[1]) == 2'h1
		|-> clr_cnt_reg != 4'h0)
		else $error("transfer request dropped without clear");
endmodule : dbs_sel_checker
bind duplex_bus_port_selector dbs_sel_checker dbs_sel_checker_i (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
	.BUS_ADDR_I(BUS_ADDR_I), .BUS_WRITE_I(BUS_WRITE_I), .BUS_READ_I(BUS_READ_I),
	.BUS_POLL_I(BUS_POLL_I), .BUS_TAKEOVER_I(BUS_TAKEOVER_I), .BUS_CLOCK_I(BUS_CLOCK_I),
	.RESP_PULSE_O(RESP_PULSE_O), .RESP_LEVEL_O(RESP_LEVEL_O), .ATTN_PULSE_O(ATTN_PULSE_O),
	.WORD_PULSE_O(WORD_PULSE_O), .SIDE_MODE_O(SIDE_MODE_O), .DEV_COMMAND_O(DEV_COMMAND_O),
	.DEV_WRITE_O(DEV_WRITE_O), .DEV_READ_O(DEV_READ_O), .DEV_CLOCK_O(DEV_CLOCK_O));
`default_nettype wire

// ==== verif/periph_model.sv ====
// Behavioural peripheral device on the selector's device side.
// Assumes active-high device bus levels and the system clock.
`timescale 1ns/1ps
`default_nettype none
module periph_model
#(
	parameter logic [5:0] MY_ADDR = 6'h01
)
(
	input  wire logic        clk_i,
	input  wire logic [5:0]  addr_i,
	input  wire logic        cmd_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        st_i,
	input  wire logic        req_i,
	input  wire logic [17:0] data_i,
	output logic             echo_o,
	output logic             idle_o,
	output logic             fault_o,
	output logic             attn_o,
	output logic             req_o,
	output logic [17:0]      word_o
);
	logic sel;
	assign sel = (addr_i == MY_ADDR) && (cmd_i || wr_i || rd_i || st_i);
	initial {echo_o, idle_o, fault_o, attn_o, req_o, word_o} = '0;
	always @(posedge clk_i)
	begin
		echo_o <= sel;
		idle_o <= sel;
		fault_o <= sel && cmd_i;
		attn_o <= 1'b0;
		if (wr_i || rd_i)
			req_o <= 1'b0;
		else if (req_i)
			req_o <= 1'b1;
		// Released lines toggle so a stale word never looks valid.
		word_o <= (sel && (rd_i || st_i)) ? data_i : ~word_o;
	end
endmodule : periph_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the duplex bus port selector with a peripheral model.
// Assumes the bound checker; side 1 is the maintenance side most of the run.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {logic side; logic [17:0] w; logic chk;} note_t;
	logic             clk;
	logic             rst_n;
	logic [1:0][5:0]  addr;
	logic [5:0][1:0]  stb;
	logic [1:0][17:0] word;
	logic [1:0]       lclk;
	logic [1:0][3:0]  rp;
	logic [1:0][3:0]  rl;
	logic [1:0][17:0] wp;
	logic [1:0][1:0]  mode;
	logic [5:0]       d_addr;
	logic             d_cmd, d_wr, d_rd, d_st, d_oe, echo, idle, fault, attn, req, req_arm;
	logic [17:0]      d_wo, m_word, d_wire, ddata, lw;
	logic [1:0]       rp_q;
	logic [31:0]      seed = 32'h4b;
	logic             loose;
	logic             pwr = 1'b1;
	note_t            q[$];
	note_t            nt;
	int               n_fail;
	int               checks;
	assign d_wire = d_oe ? d_wo : m_word;
	duplex_bus_port_selector duplex_bus_port_selector_i (.CLK_I(clk), .RESET_N_I(rst_n),
		.POWER_GOOD_I(pwr), .STRAP_ADDR_I(5'h02), .STRAP_CODE_I(6'h07), .BUS_ADDR_I(addr),
		.BUS_COMMAND_I(stb[0]), .BUS_WRITE_I(stb[1]), .BUS_READ_I(stb[2]), .BUS_STATUS_I(stb[3]),
		.BUS_POLL_I(stb[4]), .BUS_TAKEOVER_I(stb[5]), .BUS_WORD_I(word), .BUS_CLOCK_I(lclk),
		.RESP_PULSE_O(rp), .RESP_LEVEL_O(rl), .ATTN_PULSE_O(), .WORD_PULSE_O(wp),
		.SIDE_MODE_O(mode), .DEV_ECHO_I(echo), .DEV_IDLE_I(idle), .DEV_FAULT_I(fault),
		.DEV_ATTN_I(attn), .DEV_REQUEST_I(req), .DEV_WORD_I(d_wire), .DEV_ADDR_O(d_addr),
		.DEV_COMMAND_O(d_cmd), .DEV_WRITE_O(d_wr), .DEV_READ_O(d_rd), .DEV_STATUS_O(d_st),
		.DEV_POLL_O(), .DEV_CLOCK_O(), .DEV_WORD_O(d_wo), .DEV_WORD_OE_O(d_oe));
	periph_model periph_model_i (.clk_i(clk), .addr_i(d_addr), .cmd_i(d_cmd), .wr_i(d_wr),
		.rd_i(d_rd), .st_i(d_st), .req_i(req_arm), .data_i(ddata), .echo_o(echo), .idle_o(idle),
		.fault_o(fault), .attn_o(attn), .req_o(req), .word_o(m_word));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// The processor clocks run free and out of phase with the system clock.
	initial
	begin
		lclk = 2'h0;
		#37;
		forever #200 lclk = ~lclk;
	end
	function automatic logic [17:0] mkword(input logic [15:0] d);
		return {~^d[15:8], ~^d[7:0], d};
	endfunction : mkword
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	task automatic end_sim();
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic mchk(input dbs_sel_pkg::mode_t m0, input dbs_sel_pkg::mode_t m1);
		chk(18'(mode[0]), 18'(m0));
		chk(18'(mode[1]), 18'(m1));
	endtask : mchk
	// Answer kind e: 0 none, 1 unchecked word, 2 not judged, 3 word xw.
	task automatic op(input int s, input int k, input logic [5:0] a, input logic [17:0] w,
		input int e, input logic [17:0] xw);
		@(posedge clk);
		addr[s] <= a;
		word[s] <= w;
		loose <= (e == 2);
		if (e == 1 || e == 3)
			q.push_back(note_t'{s[0], xw, e == 3});
		repeat (3) @(posedge clk);
		stb[k][s] <= 1'b1;
		repeat (8) @(posedge clk);
		stb[k][s] <= 1'b0;
		repeat (10) @(posedge clk);
		loose <= 1'b0;
		chk(18'(q.size()), 18'h0);
		q.delete();
	endtask : op
	task automatic cmd(input int s, input logic [4:0] c, input int e);
		op(s, dbs_sel_pkg::STB_CMD, 6'h02, mkword({11'h0, c}), e, 18'h0);
	endtask : cmd
	// Every rising echo of positive sense outside a loose operation consumes the oldest note.
	always @(posedge clk)
	begin
		for (int s = 0; s < 2; s++)
		begin
			if (rp[s][0] === 1'b1 && rp_q[s] === 1'b0 && rl[s][0] === 1'b1 && !loose)
			begin
				if (q.size() == 0)
					chk(18'h1, 18'h0);
				else
				begin
					nt = q.pop_front();
					chk(18'(nt.side), 18'(s));
					if (nt.chk)
						chk(wp[s], nt.w);
				end
			end
			rp_q[s] = rp[s][0];
		end
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	initial
	begin
		{addr, stb, word, rp_q, loose, req_arm, n_fail, checks} = '0;
		rst_n = 1'b0;
		ddata = mkword(rnd());
		lw = mkword(rnd());
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		mchk(dbs_sel_pkg::MODE_OUT, dbs_sel_pkg::MODE_OUT);
		cmd(1, dbs_sel_pkg::CMD_PORT_ON, 2);
		mchk(dbs_sel_pkg::MODE_OUT, dbs_sel_pkg::MODE_MAINT);
		op(1, dbs_sel_pkg::STB_WR, 6'h02, lw, 1, 18'h0);
		op(1, dbs_sel_pkg::STB_RD, 6'h02, ~lw, 3, lw);
		op(1, dbs_sel_pkg::STB_POLL, 6'h3c, 18'h0, 3, 18'h3ffff);
		op(1, dbs_sel_pkg::STB_POLL, 6'h02, 18'h0, 0, 18'h0);
		op(0, dbs_sel_pkg::STB_TAKE, 6'h3c, 18'h0, 2, 18'h0);
		mchk(dbs_sel_pkg::MODE_NORMAL, dbs_sel_pkg::MODE_OUT);
		cmd(1, dbs_sel_pkg::CMD_PORT_ON, 2);
		cmd(1, dbs_sel_pkg::CMD_ROUTE_SET, 2);
		mchk(dbs_sel_pkg::MODE_NORMAL, dbs_sel_pkg::MODE_MAINT);
		op(1, dbs_sel_pkg::STB_ST, 6'h02, 18'h0, 3, mkword({10'h3c4, 6'h07}));
		req_arm <= 1'b1;
		op(0, dbs_sel_pkg::STB_RD, 6'h01, 18'h0, 3, ddata);
		req_arm <= 1'b0;
		op(0, dbs_sel_pkg::STB_RD, 6'h04, 18'h0, 0, 18'h0);
		op(0, dbs_sel_pkg::STB_CMD, 6'h01, mkword(16'h0a20), 1, 18'h0);
		cmd(1, dbs_sel_pkg::CMD_XFER_SET, 1);
		repeat (30) @(posedge clk);
		chk(18'(rl[1][3]), 18'h1);
		op(1, dbs_sel_pkg::STB_WR, 6'h02, lw, 1, 18'h0);
		chk(18'(rl[1][3]), 18'h0);
		cmd(1, dbs_sel_pkg::CMD_XFER_SET, 1);
		op(1, dbs_sel_pkg::STB_TAKE, 6'h02, 18'h0, 2, 18'h0);
		chk(18'(rl[1][3]), 18'h0);
		mchk(dbs_sel_pkg::MODE_NORMAL, dbs_sel_pkg::MODE_MAINT);
		cmd(1, dbs_sel_pkg::CMD_NONE, 1);
		cmd(1, dbs_sel_pkg::CMD_ATTN, 1);
		cmd(1, dbs_sel_pkg::CMD_ROUTE_CLR, 1);
		mchk(dbs_sel_pkg::MODE_NORMAL, dbs_sel_pkg::MODE_MAINT);
		cmd(1, dbs_sel_pkg::CMD_PORT_OFF, 2);
		mchk(dbs_sel_pkg::MODE_NORMAL, dbs_sel_pkg::MODE_OUT);
		op(1, dbs_sel_pkg::STB_TAKE, 6'h3c, 18'h0, 2, 18'h0);
		mchk(dbs_sel_pkg::MODE_OUT, dbs_sel_pkg::MODE_NORMAL);
		pwr <= 1'b0;
		repeat (4) @(posedge clk);
		mchk(dbs_sel_pkg::MODE_OUT, dbs_sel_pkg::MODE_OUT);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
